// *** hw/sfd_host.sv ***
/*
 * host end: runs CHAIN 24-bit frames under one chip-select per request, derives sck by a divider.
 * assumes the target samples on falling sck and updates on rising sck.
 */
module sfd_host #(
	parameter int HALF = sfd_pkg::SCK_HALF_CYC,
	parameter int CHAIN = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// link
	sfd_if.host lnk,
	// request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [sfd_pkg::FRAME_BITS*CHAIN-1:0] req_frame,
	// answer
	output logic rsp_valid,
	output logic [sfd_pkg::FRAME_BITS*CHAIN-1:0] rsp_frame
);
	localparam int NB = sfd_pkg::FRAME_BITS * CHAIN;
	typedef enum logic [1:0] {IDLE, SHIFT, DONE} sfd_st_e;

	logic miso_s;
	sfd_sync #(.INIT(1'b0)) u_miso (.clk(clk), .nrst(nrst), .ce(ce), .d(lnk.miso_o), .q(miso_s));

	sfd_st_e st_r, st_nxt;
	logic [15:0] div_r, div_nxt;
	logic [15:0] bits_r, bits_nxt;
	logic [NB-1:0] tx_r, tx_nxt, rx_r, rx_nxt;
	logic cs_n_r, cs_n_nxt, sck_r, sck_nxt, rv_nxt;
	logic tick;

	assign tick = (div_r == 16'(HALF - 1));
	assign req_ready = (st_r == IDLE);

	always_comb begin
		st_nxt = st_r;
		div_nxt = div_r;
		bits_nxt = bits_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		cs_n_nxt = cs_n_r;
		sck_nxt = sck_r;
		rv_nxt = rsp_valid;
		if (ce) begin
			rv_nxt = 1'b0;
			div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
			unique case (st_r)
				IDLE: begin
					div_nxt = 16'h0000;
					if (req_valid) begin
						tx_nxt = req_frame;
						cs_n_nxt = 1'b0;
						bits_nxt = 16'(NB);
						st_nxt = SHIFT;
					end
				end
				SHIFT: begin
					if (tick) begin
						sck_nxt = !sck_r;
						if (sck_r) begin
							// falling edge: target samples mosi, host samples miso
							rx_nxt = {rx_r[NB-2:0], miso_s};
							bits_nxt = bits_r - 16'h0001;
							if (bits_r == 16'h0001) begin
								st_nxt = DONE;
							end
						end else if (bits_r != 16'(NB)) begin
							// next bit moves on the rise so it is settled at the fall
							tx_nxt = {tx_r[NB-2:0], 1'b0};
						end
					end
				end
				DONE: begin
					if (tick) begin
						cs_n_nxt = 1'b1;
						rv_nxt = 1'b1;
						st_nxt = IDLE;
					end
				end
				default: st_nxt = IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= IDLE;
			div_r <= '0;
			bits_r <= '0;
			tx_r <= '0;
			rx_r <= '0;
			cs_n_r <= 1'b1;
			sck_r <= 1'b0;
			rsp_valid <= 1'b0;
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			bits_r <= bits_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			cs_n_r <= cs_n_nxt;
			sck_r <= sck_nxt;
			rsp_valid <= rv_nxt;
		end
	end

	assign rsp_frame = rx_r;
	assign lnk.cs_n = cs_n_r;
	assign lnk.sck = sck_r;
	assign lnk.mosi = tx_r[NB-1];
endmodule : sfd_host

// *** hw/sfd_sync.sv ***
/*
 * two-flop synchroniser for one pin level.
 * assumes the input is asynchronous to clk.
 */
module sfd_sync #(
	parameter logic INIT = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// level
	input wire logic d,
	output logic q
);
	logic s1_r;
	logic s1_nxt;
	logic q_nxt;

	always_comb begin
		s1_nxt = s1_r;
		q_nxt = q;
		if (ce) begin
			s1_nxt = d;
			q_nxt = s1_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_r <= INIT;
			q <= INIT;
		end else begin
			s1_r <= s1_nxt;
			q <= q_nxt;
		end
	end
endmodule : sfd_sync

// *** hw/sfd_target.sv ***
/*
 * framed serial target: 24-bit shifter, commit on chip-select rise, 128x16 bank.
 * assumes the link pins are asynchronous and sampled by clk well above sck rate.
 */
module sfd_target #(
	parameter bit DAISY = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// link
	sfd_if.target lnk,
	// user side
	output logic [sfd_pkg::SEL_W-1:0] wr_sel,
	output logic [sfd_pkg::DATA_W-1:0] wr_data,
	output logic wr_stb,
	output logic bad_frame
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic cs_n_s;
	logic sck_s;
	logic mosi_s;

	sfd_sync #(.INIT(1'b1)) u_cs (.clk(clk), .nrst(nrst), .ce(ce), .d(lnk.cs_n), .q(cs_n_s));
	sfd_sync #(.INIT(1'b0)) u_sck (.clk(clk), .nrst(nrst), .ce(ce), .d(lnk.sck), .q(sck_s));
	sfd_sync #(.INIT(1'b0)) u_mosi (.clk(clk), .nrst(nrst), .ce(ce), .d(lnk.mosi), .q(mosi_s));

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef logic [sfd_pkg::DATA_W-1:0] sfd_word_t;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(sfd_pkg::FRAME_BITS);

	logic cs_n_r, cs_n_nxt;
	logic sck_r, sck_nxt;
	logic [sfd_pkg::FRAME_BITS-1:0] sh_r, sh_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic over_r, over_nxt;
	logic miso_r, miso_nxt;
	logic rd_pend_r, rd_pend_nxt;
	logic [sfd_pkg::SEL_W-1:0] rd_sel_r, rd_sel_nxt;
	logic [sfd_pkg::SEL_W-1:0] wr_sel_nxt;
	sfd_word_t wr_data_nxt;
	logic wr_stb_nxt;
	logic bad_nxt;
	sfd_word_t bank_r [sfd_pkg::REG_COUNT];
	logic oe_n_r, oe_n_nxt;

	logic cs_fall, cs_rise, sck_fall, sck_rise, frame_ok;

	assign cs_fall = cs_n_r && !cs_n_s;
	assign cs_rise = !cs_n_r && cs_n_s;
	assign sck_fall = sck_r && !sck_s && !cs_n_s;
	assign sck_rise = !sck_r && sck_s && !cs_n_s;
	// daisy use accepts any multiple; standalone wants exactly one frame
	assign frame_ok = DAISY ? (cnt_r == CNT_FRAME) : (cnt_r == CNT_FRAME && !over_r);

	always_comb begin
		cs_n_nxt = cs_n_r;
		sck_nxt = sck_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		over_nxt = over_r;
		miso_nxt = miso_r;
		rd_pend_nxt = rd_pend_r;
		rd_sel_nxt = rd_sel_r;
		wr_sel_nxt = wr_sel;
		wr_data_nxt = wr_data;
		wr_stb_nxt = wr_stb;
		bad_nxt = bad_frame;
		oe_n_nxt = oe_n_r;
		if (ce) begin
			wr_stb_nxt = 1'b0;
			bad_nxt = 1'b0;
			cs_n_nxt = cs_n_s;
			sck_nxt = sck_s;
			if (cs_fall) begin
				cnt_nxt = '0;
				over_nxt = 1'b0;
				oe_n_nxt = 1'b0;
				// load reply: previous read data, else zero where undefined
				sh_nxt = '0;
				if (rd_pend_r) begin
					sh_nxt[sfd_pkg::DATA_HI:0] = bank_r[rd_sel_r];
				end
				miso_nxt = sh_nxt[sfd_pkg::RW_POS];
			end else if (!cs_n_s) begin
				if (sck_rise && cnt_r != '0) begin
					miso_nxt = sh_r[sfd_pkg::RW_POS];
				end
				if (sck_fall) begin
					sh_nxt = {sh_r[sfd_pkg::RW_POS-1:0], mosi_s};
					if (cnt_r == CNT_FRAME) begin
						over_nxt = 1'b1;
						cnt_nxt = CNT_W'(1);
					end else begin
						cnt_nxt = cnt_r + CNT_W'(1);
					end
				end
			end
			if (cs_rise) begin
				oe_n_nxt = 1'b1;
				// the output registers below act as the input register
				if (frame_ok) begin
					if (sh_r[sfd_pkg::RW_POS] == sfd_pkg::RW_WRITE) begin
						wr_sel_nxt = sh_r[sfd_pkg::SEL_HI:sfd_pkg::SEL_LO];
						wr_data_nxt = sh_r[sfd_pkg::DATA_HI:0];
						wr_stb_nxt = 1'b1;
						rd_pend_nxt = 1'b0;
					end else begin
						rd_sel_nxt = sh_r[sfd_pkg::SEL_HI:sfd_pkg::SEL_LO];
						rd_pend_nxt = 1'b1;
					end
				end else begin
					bad_nxt = 1'b1;
					rd_pend_nxt = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cs_n_r <= 1'b1;
			sck_r <= 1'b0;
			sh_r <= '0;
			cnt_r <= '0;
			over_r <= 1'b0;
			miso_r <= 1'b0;
			rd_pend_r <= 1'b0;
			rd_sel_r <= '0;
			wr_sel <= '0;
			wr_data <= '0;
			wr_stb <= 1'b0;
			bad_frame <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			cs_n_r <= cs_n_nxt;
			sck_r <= sck_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			over_r <= over_nxt;
			miso_r <= miso_nxt;
			rd_pend_r <= rd_pend_nxt;
			rd_sel_r <= rd_sel_nxt;
			wr_sel <= wr_sel_nxt;
			wr_data <= wr_data_nxt;
			wr_stb <= wr_stb_nxt;
			bad_frame <= bad_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	// write lands one cycle after commit, from the decoded input register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < sfd_pkg::REG_COUNT; i++) begin
				bank_r[i] <= sfd_pkg::REG_RESET;
			end
		end else if (ce && wr_stb) begin
			bank_r[wr_sel] <= wr_data;
		end
	end

	assign lnk.miso_o = miso_r;
	assign lnk.miso_oe_n = oe_n_r;
endmodule : sfd_target

// *** inc/sfd_if.sv ***
/*
 * serial link between host and target: chip-select, clock, data in, data out.
 * assumes the bench resolves the target's three-state output from its enable.
 */
interface sfd_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso_o;
	logic miso_oe_n;
	modport host (output cs_n, output sck, output mosi, input miso_o, input miso_oe_n);
	modport target (input cs_n, input sck, input mosi, output miso_o, output miso_oe_n);
endinterface : sfd_if

// *** inc/sfd_pkg.sv ***
/*
 * shared constants for the 24-bit framed serial target link and its host.
 * assumes both ends run on one 200 MHz system clock.
 */
package sfd_pkg;
	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 24;
	localparam int RW_POS = 23;
	localparam int SEL_HI = 22;
	localparam int SEL_LO = 16;
	localparam int SEL_W = 7;
	localparam int DATA_W = 16;
	localparam int DATA_HI = 15;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	// ----------------------------------------
	// timing and register bank
	// ----------------------------------------
	localparam int CLK_NS = 5;
	localparam int SCK_HALF_NS = 40;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int REG_COUNT = 128;
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
endpackage : sfd_pkg

// *** verification/sfd_chk.sv ***
/*
 * sfd_chk: concurrent checks on the serial link between host and target.
 * assumes the host divider of 8 clk per sck half and one frame per chip-select.
 */
module sfd_chk (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// falling sck edges in the open frame
	// ----------------------------------------
	logic [7:0] falls_r;
	logic [7:0] falls_nxt;
	logic sck_r;
	logic sck_nxt;
	always_comb begin
		sck_nxt = sck;
		falls_nxt = cs_n ? 8'h00 : falls_r + {7'h00, sck_r & ~sck};
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			falls_r <= 8'h00;
			sck_r <= 1'b0;
		end else begin
			falls_r <= falls_nxt;
			sck_r <= sck_nxt;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// margin of 5 covers the target's pin synchroniser
	chk_oe_idle: assert property (cs_n[*5] |-> miso_oe_n)
		else $error("target drives while deselected");
	chk_oe_drive: assert property ((!cs_n)[*6] |-> !miso_oe_n)
		else $error("target silent while selected");
	chk_sck_idle: assert property (cs_n |-> !sck)
		else $error("sck high outside a frame");
	chk_sck_high: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("sck high phase not 8 cycles");
	chk_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi moved while sck high");
	chk_miso_hold: assert property ((!sck && !cs_n)[*6] |-> $stable(miso_o))
		else $error("miso moved while sck low");
	chk_frame_len: assert property ($rose(cs_n) |-> falls_r == 8'h18)
		else $error("frame not 24 falling edges");
	chk_cs_gap: assert property ($rose(cs_n) |-> cs_n[*4])
		else $error("chip-select gap too short");
	chk_sck_start: assert property ($fell(cs_n) |-> (!sck)[*4] ##[1:12] sck)
		else $error("first sck edge out of place");
endmodule : sfd_chk

// *** verification/sfd_tb_top.sv ***
/*
 * sfd_tb_top: host and target on one link, a standalone and a chaining target driven by hand.
 * assumes a 200 MHz clk and the host's default sck divider.
 */
module sfd_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0;
	logic ce = 1'b1;
	logic req_ready, rsp_valid, wr_stb, bad, stb2, bad2, stb3, bad3;
	logic [23:0] req_frame = 24'h000000;
	logic [23:0] rsp_frame;
	logic [23:0] mon = 24'h000000;
	logic [23:0] mon3 = 24'h000000;
	logic [6:0] wr_sel, sel2, sel3;
	logic [15:0] wr_data, data2, data3;
	int n_mismatch = 0, n_tests = 0, n_wr = 0, n_bad = 0, n_wr2 = 0, n_bad2 = 0;
	int n_wr3 = 0, n_bad3 = 0;
	sfd_if lnk();
	sfd_if lnk2();
	sfd_if lnk3();
	// lnk3 mirrors the hand-driven pins into a chaining target
	assign lnk3.cs_n = lnk2.cs_n;
	assign lnk3.sck = lnk2.sck;
	assign lnk3.mosi = lnk2.mosi;
	always #2.5 clk = ~clk;
	sfd_host #(.CHAIN(1)) sfd_host_inst (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk),
		.req_valid(req_valid), .req_ready(req_ready), .req_frame(req_frame),
		.rsp_valid(rsp_valid), .rsp_frame(rsp_frame));
	sfd_target #(.DAISY(1'b0)) sfd_target_inst (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk),
		.wr_sel(wr_sel), .wr_data(wr_data), .wr_stb(wr_stb), .bad_frame(bad));
	sfd_target #(.DAISY(1'b0)) sfd_target_inst2 (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk2),
		.wr_sel(sel2), .wr_data(data2), .wr_stb(stb2), .bad_frame(bad2));
	sfd_target #(.DAISY(1'b1)) sfd_target_inst3 (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk3),
		.wr_sel(sel3), .wr_data(data3), .wr_stb(stb3), .bad_frame(bad3));
	sfd_chk sfd_chk_inst (.clk(clk), .nrst(nrst), .cs_n(lnk.cs_n), .sck(lnk.sck),
		.mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe_n(lnk.miso_oe_n));
	// ----------------------------------------
	// monitors and tasks
	// ----------------------------------------
	always @(negedge lnk.sck) if (!lnk.cs_n) mon <= {mon[22:0], lnk.mosi};
	always @(negedge lnk2.sck) if (!lnk2.cs_n) mon3 <= {mon3[22:0], lnk3.miso_o};
	always @(posedge clk) begin
		if (stb3 === 1'b1) n_wr3++;
		if (bad3 === 1'b1) n_bad3++;
		if (wr_stb === 1'b1) n_wr++;
		if (bad === 1'b1) n_bad++;
		if (stb2 === 1'b1) n_wr2++;
		if (bad2 === 1'b1) n_bad2++;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test
	// bounded: a hang counts as a mismatch
	task automatic wait_hi(ref logic s);
		int i;
		for (i = 0; i < 1000 && s !== 1'b1; i++) @(negedge clk);
		if (i == 1000) begin
			n_mismatch++;
			finish_test();
		end
	endtask : wait_hi
	task automatic xfer(input logic [23:0] f);
		@(negedge clk);
		req_frame = f;
		req_valid = 1'b1;
		wait_hi(req_ready);
		@(negedge clk);
		req_valid = 1'b0;
		wait_hi(rsp_valid);
		check(mon, f);
		repeat (10) @(negedge clk);
	endtask : xfer
	// hand-made frame of n sck cycles, f repeated; mosi moves mid low phase
	task automatic bang(input logic [23:0] f, input int n);
		@(negedge clk);
		lnk2.cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			#20 lnk2.mosi = f[23 - (i % 24)];
			#20 lnk2.sck = 1'b1;
			#40 lnk2.sck = 1'b0;
		end
		#40 lnk2.cs_n = 1'b1;
		lnk2.mosi = ~lnk2.mosi;
		#100;
	endtask : bang
	initial begin
		lnk2.cs_n = 1'b1;
		lnk2.sck = 1'b0;
		lnk2.mosi = 1'b0;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		xfer(24'h05a5c3);
		check(24'(wr_sel), 24'h000005);
		check(24'(wr_data), 24'h00a5c3);
		xfer(24'h7f3c5a);
		check(24'(wr_sel), 24'h00007f);
		xfer(24'h85ffff);
		check(24'(n_wr), 24'h000002);
		xfer(24'hff0000);
		check(rsp_frame, 24'h00a5c3);
		xfer(24'h050001);
		check(rsp_frame, 24'h003c5a);
		xfer(24'h85aaaa);
		xfer(24'h800000);
		check(rsp_frame, 24'h000001);
		check(24'(n_bad), 24'h000000);
		bang(24'h0a1234, 23);
		bang(24'h0a1234, 25);
		check(24'(n_bad2), 24'h000002);
		check(24'(n_wr2), 24'h000000);
		check(24'(n_bad3), 24'h000002);
		check(24'(n_wr3), 24'h000000);
		repeat (3) begin
			#40 lnk2.sck = 1'b1;
			#40 lnk2.sck = 1'b0;
		end
		bang(24'h0a1234, 24);
		check(24'(n_wr2), 24'h000001);
		check({1'b0, sel2, data2}, 24'h0a1234);
		check(24'(n_wr3), 24'h000001);
		// two frames in one select: standalone refuses, chaining commits the last
		bang(24'h0a1234, 48);
		check(24'(n_bad2), 24'h000003);
		check(24'(n_wr3), 24'h000002);
		check(mon3, 24'h0a1234);
		check({1'b0, sel3, data3}, 24'h0a1234);
		// frozen ends must ignore a whole frame
		@(negedge clk);
		ce = 1'b0;
		bang(24'h0a1234, 24);
		ce = 1'b1;
		check(24'(n_wr2 + n_bad2), 24'h000004);
		check(24'(n_wr3 + n_bad3), 24'h000004);
		finish_test();
	end
endmodule : sfd_tb_top
